// >>> fcs_cfg.svh
// constants for the file command sequencer: the host mode value, parameter
// patterns, status codes and the file size ceiling.
// assumes nothing; included by the package users only.
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

`define FCS_MODE_HOST 8'h03
`define FCS_PTR_END 32'hFFFF_FFFF
`define FCS_PTR_START 32'h0000_0000
`define FCS_CLOSE_UPDATE_BIT 0
`define FCS_DIR_ALL 32'h0000_00FF
`define FCS_MAX_FILE 32'h4000_0000
`define FCS_IRQ_BIT 7

`define FCS_ST_IDLE 8'h00
`define FCS_ST_OK 8'h01
`define FCS_ST_CONNECT 8'h02
`define FCS_ST_DISCONNECT 8'h03
`define FCS_ST_MISS_FILE 8'h04
`define FCS_ST_ERR 8'h05
`define FCS_ST_FULL 8'h06

`endif

// >>> fcs_pkg.sv
// types shared by the file command sequencer and its surroundings.
// assumes the command codes below are the ones the host issues.
`default_nettype none
package fcs_pkg;

    typedef enum logic [7:0] {
        FCS_C_SET_MODE = 8'h01,
        FCS_C_DISK_CONNECT = 8'h02,
        FCS_C_MOUNT = 8'h03,
        FCS_C_OPEN = 8'h04,
        FCS_C_CREATE = 8'h05,
        FCS_C_DIR_CREATE = 8'h06,
        FCS_C_SET_PTR = 8'h07,
        FCS_C_BYTE_WRITE = 8'h08,
        FCS_C_BYTE_READ = 8'h09,
        FCS_C_CLOSE = 8'h0A,
        FCS_C_READ_DIR = 8'h0B,
        FCS_C_OFFSET_WRITE = 8'h0C,
        FCS_C_SAVE_DIR = 8'h0D
    } fcs_cmd_e_t;

    typedef struct packed {
        fcs_cmd_e_t code;
        logic [31:0] param;
    } fcs_cmd_t;

    typedef struct packed {
        logic [31:0] length;
    } fcs_dir_wr_t;

    typedef enum logic [2:0] {
        FCS_S_IDLE = 3'b001,
        FCS_S_WRITE = 3'b010,
        FCS_S_FLUSH = 3'b100
    } fcs_state_t;

endpackage : fcs_pkg
`default_nettype wire

// >>> fcs_sequencer.sv
// file command sequencer: takes host commands, tracks file pointer and
// length, streams write bytes through a fifo to the medium.
// assumes medium lookup inputs are on mclk; stick_pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_cfg.svh"

module fcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic full_reg, full_next, empty_reg, empty_next;
    logic push, pop;

    always_comb begin
        push = in_valid && !full_reg;
        pop = out_ready && !empty_reg;
        wp_next = push ? ((wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
        rp_next = pop ? ((rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
        cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        full_next = (cnt_next == (AW + 1)'(DEPTH));
        empty_next = (cnt_next == '0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            full_reg <= full_next;
            empty_reg <= empty_next;
        end
    end

    // storage has no reset; contents are qualified by the count
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    assign in_ready = !full_reg;
    assign out_valid = !empty_reg;
    assign out_data = mem[rp_reg];
endmodule : fcs_fifo

module fcs_sequencer #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire fcs_pkg::fcs_cmd_t cmd,
    output logic cmd_ready,
    input wire logic host_data_valid,
    input wire logic [7:0] host_data,
    output logic host_data_ready,
    input wire logic status_rd,
    output logic int_n,
    output logic [7:0] status_port,
    output logic [7:0] status_code,
    output logic [31:0] resp_value,
    input wire logic stick_pin,
    input wire logic file_exists,
    input wire logic [31:0] file_len_in,
    output logic media_wr_valid,
    output logic [7:0] media_wr_data,
    input wire logic media_wr_ready,
    output logic dir_wr_valid,
    output fcs_pkg::fcs_dir_wr_t dir_wr
);
    logic [1:0] rs_reg;
    logic rst_n;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rs_reg <= 2'b00;
        end else begin
            rs_reg <= {rs_reg[0], 1'b1};
        end
    end
    assign rst_n = rs_reg[1];

    function automatic logic [31:0] min32(input logic [31:0] a, input logic [31:0] b);
        min32 = (a < b) ? a : b;
    endfunction : min32

    fcs_pkg::fcs_state_t state_reg, state_next;
    logic s1_reg, s2_reg, s3_reg, present_reg, present_next;
    logic mode_reg, mode_next, mounted_reg, mounted_next, open_reg, open_next;
    logic [31:0] ptr_reg, ptr_next, len_reg, len_next, remain_reg, remain_next;
    logic [31:0] resp_reg, resp_next;
    logic [7:0] code_reg, code_next;
    logic pend_reg, pend_next, conn_reg, conn_next, rdy_reg, rdy_next;
    logic mv_reg, mv_next, dv_reg, dv_next;
    logic [7:0] md_reg, md_next;
    logic [31:0] dl_reg, dl_next;
    logic accept, done, pop, f_valid;
    logic [7:0] f_data, done_code;

    fcs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(host_data_valid),
        .in_data(host_data),
        .in_ready(host_data_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(pop)
    );

    always_comb begin
        accept = cmd_valid && rdy_reg;
        state_next = state_reg;
        present_next = (s2_reg == s3_reg) ? s3_reg : present_reg;
        mode_next = mode_reg;
        mounted_next = mounted_reg && present_reg;
        open_next = open_reg && present_reg;
        ptr_next = ptr_reg;
        len_next = len_reg;
        remain_next = remain_reg;
        resp_next = resp_reg;
        dv_next = 1'b0;
        dl_next = dl_reg;
        done = 1'b0;
        done_code = `FCS_ST_OK;
        pop = 1'b0;
        mv_next = mv_reg && !media_wr_ready;
        md_next = md_reg;
        rdy_next = rdy_reg;
        case (state_reg)
            fcs_pkg::FCS_S_IDLE: begin
                if (accept) begin
                    done = 1'b1;
                    case (cmd.code)
                        fcs_pkg::FCS_C_SET_MODE: begin
                            mode_next = (cmd.param[7:0] == `FCS_MODE_HOST);
                            done_code = mode_next ? `FCS_ST_OK : `FCS_ST_ERR;
                        end
                        fcs_pkg::FCS_C_DISK_CONNECT: begin
                            done_code = present_reg ? `FCS_ST_OK : `FCS_ST_DISCONNECT;
                        end
                        fcs_pkg::FCS_C_MOUNT: begin
                            mounted_next = present_reg && mode_reg;
                            done_code = mounted_next ? `FCS_ST_OK : `FCS_ST_ERR;
                        end
                        fcs_pkg::FCS_C_OPEN: begin
                            if (!mounted_reg) begin
                                done_code = `FCS_ST_ERR;
                            end else if (!file_exists) begin
                                done_code = `FCS_ST_MISS_FILE;
                            end else begin
                                open_next = 1'b1;
                                ptr_next = `FCS_PTR_START;
                                len_next = min32(file_len_in, `FCS_MAX_FILE);
                            end
                        end
                        fcs_pkg::FCS_C_CREATE, fcs_pkg::FCS_C_DIR_CREATE: begin
                            open_next = mounted_reg;
                            ptr_next = `FCS_PTR_START;
                            len_next = '0;
                            done_code = mounted_reg ? `FCS_ST_OK : `FCS_ST_ERR;
                        end
                        fcs_pkg::FCS_C_SET_PTR: begin
                            // all ones and any value past the end both clamp to the length
                            ptr_next = open_reg ? min32(cmd.param, len_reg) : ptr_reg;
                            done_code = open_reg ? `FCS_ST_OK : `FCS_ST_ERR;
                        end
                        fcs_pkg::FCS_C_BYTE_WRITE: begin
                            remain_next = min32(cmd.param, `FCS_MAX_FILE - ptr_reg);
                            if (!open_reg) begin
                                done_code = `FCS_ST_ERR;
                            end else if (remain_next == '0) begin
                                done_code = `FCS_ST_FULL;
                            end else begin
                                done = 1'b0;
                                rdy_next = 1'b0;
                                state_next = fcs_pkg::FCS_S_WRITE;
                            end
                            resp_next = remain_next;
                        end
                        fcs_pkg::FCS_C_BYTE_READ: begin
                            resp_next = open_reg ? min32(cmd.param, len_reg - ptr_reg) : '0;
                            ptr_next = ptr_reg + resp_next;
                            done_code = open_reg ? `FCS_ST_OK : `FCS_ST_ERR;
                        end
                        fcs_pkg::FCS_C_CLOSE: begin
                            dv_next = open_reg && cmd.param[`FCS_CLOSE_UPDATE_BIT];
                            dl_next = dv_next ? len_reg : dl_reg;
                            open_next = 1'b0;
                        end
                        fcs_pkg::FCS_C_READ_DIR: begin
                            resp_next = len_reg;
                            done_code = (open_reg && cmd.param == `FCS_DIR_ALL) ? `FCS_ST_OK : `FCS_ST_ERR;
                        end
                        fcs_pkg::FCS_C_OFFSET_WRITE: begin
                            len_next = open_reg ? min32(cmd.param, `FCS_MAX_FILE) : len_reg;
                            done_code = open_reg ? `FCS_ST_OK : `FCS_ST_ERR;
                        end
                        fcs_pkg::FCS_C_SAVE_DIR: begin
                            dv_next = open_reg;
                            dl_next = open_reg ? len_reg : dl_reg;
                            done_code = open_reg ? `FCS_ST_OK : `FCS_ST_ERR;
                        end
                        default: begin
                            done_code = `FCS_ST_ERR;
                        end
                    endcase
                end
            end
            fcs_pkg::FCS_S_WRITE: begin
                // one byte per cycle; the medium's ready stalls the fifo, then the host
                if (f_valid && (!mv_reg || media_wr_ready)) begin
                    pop = 1'b1;
                    mv_next = 1'b1;
                    md_next = f_data;
                    ptr_next = ptr_reg + 32'h0000_0001;
                    len_next = (ptr_reg >= len_reg) ? ptr_next : len_reg;
                    remain_next = remain_reg - 32'h0000_0001;
                    if (remain_next == '0) begin
                        state_next = fcs_pkg::FCS_S_FLUSH;
                    end
                end
            end
            fcs_pkg::FCS_S_FLUSH: begin
                if (!mv_reg || media_wr_ready) begin
                    done = 1'b1;
                    rdy_next = 1'b1;
                    state_next = fcs_pkg::FCS_S_IDLE;
                end
            end
            default: begin
                state_next = fcs_pkg::FCS_S_IDLE;
                rdy_next = 1'b1;
            end
        endcase
        // attach events wait behind a pending completion instead of being lost
        conn_next = conn_reg || (present_next && !present_reg);
        code_next = code_reg;
        pend_next = pend_reg && !status_rd;
        if (done) begin
            code_next = done_code;
            pend_next = 1'b1;
        end else if (conn_reg && !pend_reg) begin
            code_next = `FCS_ST_CONNECT;
            pend_next = 1'b1;
            conn_next = present_next && !present_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= fcs_pkg::FCS_S_IDLE;
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            present_reg <= 1'b0;
            mode_reg <= 1'b0;
            mounted_reg <= 1'b0;
            open_reg <= 1'b0;
            ptr_reg <= '0;
            len_reg <= '0;
            remain_reg <= '0;
            resp_reg <= '0;
            code_reg <= `FCS_ST_IDLE;
            pend_reg <= 1'b0;
            conn_reg <= 1'b0;
            rdy_reg <= 1'b1;
            mv_reg <= 1'b0;
            md_reg <= '0;
            dv_reg <= 1'b0;
            dl_reg <= '0;
        end else begin
            state_reg <= state_next;
            s1_reg <= stick_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            present_reg <= present_next;
            mode_reg <= mode_next;
            mounted_reg <= mounted_next;
            open_reg <= open_next;
            ptr_reg <= ptr_next;
            len_reg <= len_next;
            remain_reg <= remain_next;
            resp_reg <= resp_next;
            code_reg <= code_next;
            pend_reg <= pend_next;
            conn_reg <= conn_next;
            rdy_reg <= rdy_next;
            mv_reg <= mv_next;
            md_reg <= md_next;
            dv_reg <= dv_next;
            dl_reg <= dl_next;
        end
    end

    assign cmd_ready = rdy_reg;
    assign int_n = !pend_reg;
    assign status_port = {!pend_reg, 7'h00};
    assign status_code = code_reg;
    assign resp_value = resp_reg;
    assign media_wr_valid = mv_reg;
    assign media_wr_data = md_reg;
    assign dir_wr_valid = dv_reg;
    assign dir_wr.length = dl_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_close_update_len: assert property (accept && cmd.code == fcs_pkg::FCS_C_CLOSE && open_reg && cmd.param[0]
        |=> dir_wr_valid && dir_wr.length == $past(len_reg)) else $error("close did not write length");
    a_close_keep_len: assert property (accept && cmd.code == fcs_pkg::FCS_C_CLOSE && !cmd.param[0]
        |=> !dir_wr_valid && !open_reg) else $error("close zero wrote length");
    a_ptr_to_end: assert property (accept && cmd.code == fcs_pkg::FCS_C_SET_PTR && open_reg && cmd.param == 32'hFFFF_FFFF
        |=> ptr_reg == len_reg && status_code == `FCS_ST_OK) else $error("pointer not at end");
    a_ptr_to_start: assert property (accept && cmd.code == fcs_pkg::FCS_C_SET_PTR && open_reg && cmd.param == '0
        |=> ptr_reg == '0) else $error("pointer not at start");
    a_miss_file_code: assert property (accept && cmd.code == fcs_pkg::FCS_C_OPEN && mounted_reg && !file_exists
        |=> status_code == `FCS_ST_MISS_FILE && !int_n && !open_reg) else $error("missing file not reported");
    a_append_extends: assert property (pop && ptr_reg >= len_reg
        |=> len_reg == $past(ptr_reg) + 32'h0000_0001) else $error("append did not extend length");
    a_overwrite_keeps: assert property (pop && ptr_reg < len_reg
        |=> $stable(len_reg) ##0 media_wr_valid) else $error("overwrite changed length");
    a_size_ceiling: assert property (len_reg <= 32'h4000_0000 && ptr_reg <= 32'h4000_0000)
        else $error("file beyond one gigabyte");
    a_attach_notify: assert property ($rose(present_reg) |-> ##[1:3] (code_reg == `FCS_ST_CONNECT || conn_reg))
        else $error("attach not notified");
    a_flag_active_low: assert property (pend_reg && !status_rd |=> !status_port[7] && !int_n)
        else $error("pending flag not low");
    a_flag_clears: assert property (status_rd && pend_reg && !done |=> status_port[7] && int_n)
        else $error("pending flag not cleared");
endmodule : fcs_sequencer
`default_nettype wire

// >>> fcs_medium_model.sv
// medium side model: stick presence, file lookup, byte sink and directory length store.
// assumes the sequencer samples lookups and handshakes on rising mclk.
`timescale 1ns/1ps
`default_nettype none
module fcs_medium_model #(
    parameter int INIT_LEN = 10
) (
    input wire logic mclk,
    input wire logic stick_on,
    input wire logic exists_on,
    output logic stick_pin,
    output logic file_exists,
    output logic [31:0] file_len_in,
    input wire logic media_wr_valid,
    input wire logic [7:0] media_wr_data,
    output logic media_wr_ready,
    input wire logic dir_wr_valid,
    input wire fcs_pkg::fcs_dir_wr_t dir_wr
);
    logic [7:0] rx_q[$];
    logic [31:0] stored_len;
    logic [1:0] phase;
    int dir_cnt;

    initial begin
        stored_len = INIT_LEN;
        dir_cnt = 0;
        phase = 2'h0;
        media_wr_ready = 1'b0;
    end

    assign stick_pin = stick_on;
    assign file_exists = exists_on;
    // a missing file has no length: show junk, not the last value
    assign file_len_in = exists_on ? stored_len : ~stored_len;

    // ready drops one cycle in four, so the sequencer must hold its byte
    always @(negedge mclk) begin
        phase <= phase + 2'h1;
        media_wr_ready <= (phase != 2'h0);
    end

    always @(posedge mclk) begin
        if (media_wr_valid && media_wr_ready) begin
            rx_q.push_back(media_wr_data);
        end
        if (dir_wr_valid) begin
            stored_len <= dir_wr.length;
            dir_cnt++;
        end
    end
endmodule : fcs_medium_model
`default_nettype wire

// >>> fcs_tb.sv
// self-checking bench for the file command sequencer and its write fifo.
// assumes the medium model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_cfg.svh"
module testbench;
    typedef struct {
        logic [7:0] code;
        logic [31:0] param;
        logic [7:0] st;
        logic cr;
        logic [31:0] rv;
    } fcs_row_t;

    logic mclk, resetn, cmd_valid, host_data_valid, status_rd, stick_on, exists_on;
    fcs_pkg::fcs_cmd_t cmd;
    logic [7:0] host_data, status_port, status_code, media_wr_data;
    logic cmd_ready, host_data_ready, int_n, media_wr_valid, media_wr_ready, dir_wr_valid, stick_pin, file_exists;
    logic [31:0] resp_value, file_len_in;
    fcs_pkg::fcs_dir_wr_t dir_wr;
    int miscompares, total_checks;

    fcs_row_t rows [14] = '{
        '{fcs_pkg::FCS_C_MOUNT, 32'h0, `FCS_ST_ERR, 1'b0, 32'h0},
        '{fcs_pkg::FCS_C_SET_MODE, {24'h0, `FCS_MODE_HOST}, `FCS_ST_OK, 1'b0, 32'h0},
        '{fcs_pkg::FCS_C_MOUNT, 32'h0, `FCS_ST_OK, 1'b0, 32'h0},
        '{fcs_pkg::FCS_C_OPEN, 32'h0, `FCS_ST_OK, 1'b0, 32'h0},
        '{fcs_pkg::FCS_C_SET_PTR, `FCS_PTR_START, `FCS_ST_OK, 1'b0, 32'h0},
        '{fcs_pkg::FCS_C_BYTE_READ, 32'h4, `FCS_ST_OK, 1'b1, 32'h4},
        '{fcs_pkg::FCS_C_BYTE_READ, 32'h64, `FCS_ST_OK, 1'b1, 32'h6},
        '{fcs_pkg::FCS_C_SET_PTR, `FCS_PTR_END, `FCS_ST_OK, 1'b0, 32'h0},
        '{fcs_pkg::FCS_C_BYTE_READ, 32'h5, `FCS_ST_OK, 1'b1, 32'h0},
        '{fcs_pkg::FCS_C_SET_PTR, `FCS_PTR_START, `FCS_ST_OK, 1'b0, 32'h0},
        '{fcs_pkg::FCS_C_BYTE_READ, 32'h3, `FCS_ST_OK, 1'b1, 32'h3},
        '{fcs_pkg::FCS_C_READ_DIR, 32'h1, `FCS_ST_ERR, 1'b0, 32'h0},
        '{fcs_pkg::FCS_C_READ_DIR, `FCS_DIR_ALL, `FCS_ST_OK, 1'b1, 32'hA},
        '{8'hEE, 32'h0, `FCS_ST_ERR, 1'b0, 32'h0}
    };

    fcs_sequencer #(.FIFO_DEPTH(8)) u_fcs_sequencer (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .host_data_valid(host_data_valid), .host_data(host_data),
        .host_data_ready(host_data_ready), .status_rd(status_rd), .int_n(int_n), .status_port(status_port),
        .status_code(status_code), .resp_value(resp_value), .stick_pin(stick_pin), .file_exists(file_exists),
        .file_len_in(file_len_in), .media_wr_valid(media_wr_valid), .media_wr_data(media_wr_data),
        .media_wr_ready(media_wr_ready), .dir_wr_valid(dir_wr_valid), .dir_wr(dir_wr));

    fcs_medium_model #(.INIT_LEN(10)) u_fcs_medium_model (.mclk(mclk), .stick_on(stick_on),
        .exists_on(exists_on), .stick_pin(stick_pin), .file_exists(file_exists), .file_len_in(file_len_in),
        .media_wr_valid(media_wr_valid), .media_wr_data(media_wr_data), .media_wr_ready(media_wr_ready),
        .dir_wr_valid(dir_wr_valid), .dir_wr(dir_wr));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // request held from a falling edge until a rising edge that saw ready high
    task automatic issue(input logic [7:0] code, input logic [31:0] prm);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd.code = fcs_pkg::fcs_cmd_e_t'(code);
        cmd.param = prm;
        // ready is looked at mid-cycle, never in the edge that changes it
        while (cmd_ready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask : issue

    task automatic push(input logic [7:0] b);
        @(negedge mclk);
        host_data_valid = 1'b1;
        host_data = b;
        while (host_data_ready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        @(negedge mclk);
        host_data_valid = 1'b0;
    endtask : push

    task automatic done(input logic [7:0] st, input logic cr, input logic [31:0] rv);
        int n;
        n = 0;
        while (int_n !== 1'b0 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        chk("int_n", 32'h0, {31'h0, int_n});
        chk("status_code", {24'h0, st}, {24'h0, status_code});
        chk("status_port", 32'h0, {24'h0, status_port});
        if (cr) chk("resp_value", rv, resp_value);
        status_rd = 1'b1;
        @(negedge mclk);
        status_rd = 1'b0;
        @(negedge mclk);
        chk("int_n cleared", 32'h1, {31'h0, int_n});
    endtask : done

    task automatic run(input logic [7:0] code, input logic [31:0] prm, input logic [7:0] st);
        issue(code, prm);
        done(st, 1'b0, 32'h0);
    endtask : run

    task automatic rx_chk(input int n, input logic [7:0] base);
        chk("media byte count", n, u_fcs_medium_model.rx_q.size());
        for (int i = 0; i < n && u_fcs_medium_model.rx_q.size() > 0; i++) begin
            chk("media byte", {24'h0, base + 8'(i)}, {24'h0, u_fcs_medium_model.rx_q.pop_front()});
        end
    endtask : rx_chk

    initial begin
        #(50 * 40000);
        miscompares++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        host_data_valid = 1'b0;
        host_data = 8'h00;
        status_rd = 1'b0;
        stick_on = 1'b0;
        exists_on = 1'b1;
        miscompares = 0;
        total_checks = 0;
        repeat (5) @(negedge mclk);
        chk("reset outputs", 32'h0019_8000, {11'h0, cmd_ready, int_n, media_wr_valid, dir_wr_valid,
            host_data_ready, status_port, status_code});
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        stick_on = 1'b1;
        done(`FCS_ST_CONNECT, 1'b0, 32'h0);
        $display("test reset and attach done");
        foreach (rows[i]) begin
            issue(rows[i].code, rows[i].param);
            done(rows[i].st, rows[i].cr, rows[i].rv);
        end
        $display("test table done");
        // fill the fifo before the write: eight held bytes drop ready
        run(fcs_pkg::FCS_C_SET_PTR, 32'h8, `FCS_ST_OK);
        for (int i = 0; i < 8; i++) push(8'hA0 + 8'(i));
        @(negedge mclk);
        chk("fifo full", 32'h0, {31'h0, host_data_ready});
        issue(fcs_pkg::FCS_C_BYTE_WRITE, 32'h8);
        done(`FCS_ST_OK, 1'b1, 32'h8);
        rx_chk(8, 8'hA0);
        run(fcs_pkg::FCS_C_CLOSE, 32'h1, `FCS_ST_OK);
        chk("dir writes", 32'h1, u_fcs_medium_model.dir_cnt);
        chk("stored length", 32'h10, u_fcs_medium_model.stored_len);
        $display("test overwrite and extend done");
        run(fcs_pkg::FCS_C_OPEN, 32'h0, `FCS_ST_OK);
        run(fcs_pkg::FCS_C_SET_PTR, `FCS_PTR_END, `FCS_ST_OK);
        issue(fcs_pkg::FCS_C_BYTE_WRITE, 32'h2);
        push(8'h30);
        push(8'h31);
        done(`FCS_ST_OK, 1'b1, 32'h2);
        rx_chk(2, 8'h30);
        run(fcs_pkg::FCS_C_CLOSE, 32'h0, `FCS_ST_OK);
        chk("dir writes", 32'h1, u_fcs_medium_model.dir_cnt);
        run(fcs_pkg::FCS_C_OPEN, 32'h0, `FCS_ST_OK);
        issue(fcs_pkg::FCS_C_READ_DIR, `FCS_DIR_ALL);
        done(`FCS_ST_OK, 1'b1, 32'h10);
        run(fcs_pkg::FCS_C_OFFSET_WRITE, 32'h55, `FCS_ST_OK);
        run(fcs_pkg::FCS_C_SAVE_DIR, 32'h0, `FCS_ST_OK);
        chk("saved length", 32'h55, u_fcs_medium_model.stored_len);
        run(fcs_pkg::FCS_C_CLOSE, 32'h0, `FCS_ST_OK);
        chk("dir writes", 32'h2, u_fcs_medium_model.dir_cnt);
        $display("test append and entry edit done");
        exists_on = 1'b0;
        run(fcs_pkg::FCS_C_OPEN, 32'h0, `FCS_ST_MISS_FILE);
        run(fcs_pkg::FCS_C_CREATE, 32'h0, `FCS_ST_OK);
        issue(fcs_pkg::FCS_C_BYTE_WRITE, 32'h3);
        for (int i = 0; i < 3; i++) push(8'h40 + 8'(i));
        done(`FCS_ST_OK, 1'b1, 32'h3);
        rx_chk(3, 8'h40);
        run(fcs_pkg::FCS_C_CLOSE, 32'h1, `FCS_ST_OK);
        chk("created length", 32'h3, u_fcs_medium_model.stored_len);
        run(fcs_pkg::FCS_C_DIR_CREATE, 32'h0, `FCS_ST_OK);
        run(fcs_pkg::FCS_C_CLOSE, 32'h0, `FCS_ST_OK);
        chk("dir writes", 32'h3, u_fcs_medium_model.dir_cnt);
        $display("test create file and folder done");
        // a file at the ceiling grants no bytes
        run(fcs_pkg::FCS_C_CREATE, 32'h0, `FCS_ST_OK);
        run(fcs_pkg::FCS_C_OFFSET_WRITE, `FCS_PTR_END, `FCS_ST_OK);
        run(fcs_pkg::FCS_C_SET_PTR, `FCS_PTR_END, `FCS_ST_OK);
        issue(fcs_pkg::FCS_C_BYTE_WRITE, 32'h5);
        done(`FCS_ST_FULL, 1'b1, 32'h0);
        run(fcs_pkg::FCS_C_CLOSE, 32'h0, `FCS_ST_OK);
        chk("dir writes", 32'h3, u_fcs_medium_model.dir_cnt);
        $display("test size ceiling done");
        // stick pulled and reset mid-run: mode and mount must not survive
        stick_on = 1'b0;
        resetn = 1'b0;
        @(negedge mclk);
        chk("mid reset outputs", 32'h0019_8000, {11'h0, cmd_ready, int_n, media_wr_valid, dir_wr_valid,
            host_data_ready, status_port, status_code});
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        run(fcs_pkg::FCS_C_DISK_CONNECT, 32'h0, `FCS_ST_DISCONNECT);
        run(fcs_pkg::FCS_C_MOUNT, 32'h0, `FCS_ST_ERR);
        run(fcs_pkg::FCS_C_SET_MODE, 32'h2, `FCS_ST_ERR);
        stick_on = 1'b1;
        done(`FCS_ST_CONNECT, 1'b0, 32'h0);
        run(fcs_pkg::FCS_C_DISK_CONNECT, 32'h0, `FCS_ST_OK);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
